// file: design/ssp_pkg.sv
package ssp_pkg;
  // word length of every serial lane
  localparam int unsigned WORD_BITS = 8;
  // index of the last bit of a word
  localparam logic [3:0]  BIT_LAST  = 4'h7;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DIV   = 8'h04;
  localparam logic [7:0] OFS_TX    = 8'h08;
  localparam logic [7:0] OFS_RX    = 8'h0c;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_FLAG  = 8'h14;
  localparam logic [7:0] OFS_GDIR  = 8'h18;
  localparam logic [7:0] OFS_GOUT  = 8'h1c;
  localparam logic [7:0] OFS_GIN   = 8'h20;

  // control register field positions
  localparam int unsigned C_EN     = 0;
  localparam int unsigned C_SYNC   = 1;
  localparam int unsigned C_SCKDIR = 2;
  localparam int unsigned C_C0DIR  = 3;
  localparam int unsigned C_C1DIR  = 4;
  localparam int unsigned C_FSDIR  = 5;
  localparam int unsigned C_C0TX   = 6;
  localparam int unsigned C_C1TX   = 7;
  localparam int unsigned C_GATED  = 8;

  // pin positions inside the six-pin group
  localparam int unsigned P_TXD = 0;
  localparam int unsigned P_RXD = 1;
  localparam int unsigned P_SCK = 2;
  localparam int unsigned P_C0  = 3;
  localparam int unsigned P_C1  = 4;
  localparam int unsigned P_FS  = 5;

  // values after reset
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [7:0] DIV_RESET  = 8'h0f;
  localparam logic [5:0] GPIO_RESET = 6'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/serial_rx_lane.sv
`timescale 1ns/1ps
module serial_rx_lane (
  // lane clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // pins on the lane clock
  input  wire logic       data_in,
  input  wire logic       fs_in,
  // frame sync made by the local transmitter
  input  wire logic       int_fs_in,
  // quasi-static config {use_int, gen, en}
  input  wire logic [2:0] cfg_in,
  // received word and its event toggle
  output logic      [7:0] word_out,
  output logic            tgl_out,
  // frame sync made by this lane
  output logic            fs_gen_out
);
  typedef struct packed {
    logic [2:0] cfg_s1;  // config sync, first stage
    logic [2:0] cfg_s2;  // config sync, second stage
    logic [7:0] sh;      // receive shift register
    logic [3:0] cnt;     // bits taken so far
    logic       active;  // inside a frame
    logic       fs;      // own frame sync
    logic [7:0] word;    // last full word
    logic       tgl;     // flips per word
  } lane_s;

  lane_s cur;
  lane_s next_lane;

  // one step of the receiver
  always_comb begin
    logic en;
    logic gen;
    logic seen;
    logic last;
    en = cur.cfg_s2[0];
    gen = cur.cfg_s2[1];
    // frame sync source: local tx, own, or pin
    seen = cur.cfg_s2[2] ? int_fs_in : (gen ? cur.fs : fs_in);
    last = cur.active && (cur.cnt == ssp_pkg::BIT_LAST);
    next_lane = cur;
    next_lane.cfg_s1 = cfg_in;
    next_lane.cfg_s2 = cur.cfg_s1;
    // own sync: high for the bit period in which each frame's first bit is taken
    next_lane.fs = en && gen && (last || (!cur.active && !cur.fs));
    if (!en) begin
      next_lane.active = 1'b0;
      next_lane.cnt = 4'h0;
    end else if (cur.active) begin
      next_lane.sh = {cur.sh[6:0], data_in};
      if (last) begin
        next_lane.word = {cur.sh[6:0], data_in};
        next_lane.tgl = ~cur.tgl;
        next_lane.active = 1'b0;
      end else begin
        next_lane.cnt = cur.cnt + 4'h1;
      end
    end else if (seen) begin
      // first bit comes with the frame sync
      next_lane.sh = {cur.sh[6:0], data_in};
      next_lane.cnt = 4'h1;
      next_lane.active = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
    end else begin
      cur <= next_lane;
    end
  end

  assign word_out = cur.word;
  assign tgl_out = cur.tgl;
  assign fs_gen_out = cur.fs;
endmodule

// file: design/enhanced_sync_serial_unit.sv
`timescale 1ns/1ps
// How it works
// - transmit pin shifts out transmitter word
// - receive pin bits fill receive shifter
// - bit clock pin driven or supplied
// - bit clock may run free or gated
// - sync mode: both sides on bit clock
// - async: control pin zero is rx clock
// - sync: pin zero is tx1 or flag0
// - async: control pin one is rx sync
// - sync: pin one is tx2 or flag1
// - pin two is tx, sync-rx frame sync
// - pin two output: internal frame sync
// - pin two input: partner's frame sync
// - port pins are general I/O only while en is clear
module enhanced_sync_serial_unit (
  // system clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // link clocks: bit clock wire, rx clock wire
  input  wire logic        link_clk_in,
  input  wire logic        rx_clk_in,
  // axi write address
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  // axi write data
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // axi write response
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  // axi read address
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  // axi read data
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  // transmit data pin
  input  wire logic        serial_tx_data_pin_in,
  output logic             serial_tx_data_pin_out,
  output logic             serial_tx_data_pin_oe_out,
  // receive data pin
  input  wire logic        serial_rx_data_pin_in,
  output logic             serial_rx_data_pin_out,
  output logic             serial_rx_data_pin_oe_out,
  // bit clock pin
  input  wire logic        serial_bit_clock_pin_in,
  output logic             serial_bit_clock_pin_out,
  output logic             serial_bit_clock_pin_oe_out,
  // control pin zero
  input  wire logic        serial_ctrl_pin_zero_in,
  output logic             serial_ctrl_pin_zero_out,
  output logic             serial_ctrl_pin_zero_oe_out,
  // control pin one
  input  wire logic        serial_ctrl_pin_one_in,
  output logic             serial_ctrl_pin_one_out,
  output logic             serial_ctrl_pin_one_oe_out,
  // frame sync pin
  input  wire logic        serial_frame_sync_pin_in,
  output logic             serial_frame_sync_pin_out,
  output logic             serial_frame_sync_pin_oe_out
);
  // system-clock state
  typedef struct packed {
    logic        aw_have;  // write address held
    logic [7:0]  aw_addr;
    logic        w_have;   // write data held
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [8:0]  ctrl;     // mode and directions
    logic [7:0]  div;      // half-period count minus one of bit clock
    logic [23:0] tx;       // words of tx0, tx1, tx2
    logic        req;      // flips on each accepted tx write
    logic [1:0]  flag;     // flag output levels
    logic [5:0]  gdir;     // general i/o directions
    logic [5:0]  gout;     // general i/o levels
    logic [5:0]  pin_s1;   // pin sync, first stage
    logic [5:0]  pin_s2;   // pin sync, second stage
    logic        ack_s1;
    logic        ack_s2;
    logic        busy_s1;
    logic        busy_s2;
    logic [1:0]  rt_s1;    // lane word toggles, first stage
    logic [1:0]  rt_s2;
    logic [1:0]  rt_s3;    // previous value for edge find
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        ovr;      // word lost while full
    logic [7:0]  dcnt;     // divider count
    logic        sclk;     // generated bit clock
  } clk_state_s;

  // link-clock state
  typedef struct packed {
    logic [4:0]      cfg_s1;  // {c1tx, c0tx, fsdir, sync, en}
    logic [4:0]      cfg_s2;
    logic            req_s1;
    logic            req_s2;
    logic            ack;     // follows req when word taken
    logic            active;  // a frame is going out
    logic [3:0]      cnt;     // bits shifted so far
    logic            fs;      // generated frame sync
    logic [2:0][7:0] sh;      // transmit shift registers
  } link_state_s;

  clk_state_s  cs;
  clk_state_s  next_cs;
  link_state_s ls;
  link_state_s next_ls;

  logic [5:0] pin_in_v;   // all six pin inputs
  logic [5:0] pin_out_v;  // all six pin levels
  logic [5:0] pin_oe_v;   // all six pin enables
  logic [7:0] sync_word;  // word from the bit-clock lane
  logic [7:0] async_word; // word from the rx-clock lane
  logic       sync_tgl;
  logic       async_tgl;
  logic       async_fs;   // rx frame sync made in async mode
  logic       en;
  logic       sync_mode;

  assign pin_in_v = {serial_frame_sync_pin_in, serial_ctrl_pin_one_in,
                     serial_ctrl_pin_zero_in, serial_bit_clock_pin_in,
                     serial_rx_data_pin_in, serial_tx_data_pin_in};
  assign en = cs.ctrl[ssp_pkg::C_EN];
  assign sync_mode = cs.ctrl[ssp_pkg::C_SYNC];

  // byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // true for an offset that holds a register
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      ssp_pkg::OFS_CTRL, ssp_pkg::OFS_DIV, ssp_pkg::OFS_TX,
      ssp_pkg::OFS_RX, ssp_pkg::OFS_STAT, ssp_pkg::OFS_FLAG,
      ssp_pkg::OFS_GDIR, ssp_pkg::OFS_GOUT, ssp_pkg::OFS_GIN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // bus handshakes; one write and one read at a time
  assign s_axi_awready_out = !cs.aw_have && !cs.bvalid;
  assign s_axi_wready_out = !cs.w_have && !cs.bvalid;
  assign s_axi_arready_out = !cs.rvalid;
  assign s_axi_bvalid_out = cs.bvalid;
  assign s_axi_bresp_out = cs.bresp;
  assign s_axi_rvalid_out = cs.rvalid;
  assign s_axi_rdata_out = cs.rdata;
  assign s_axi_rresp_out = cs.rresp;

  // system-clock next state
  always_comb begin
    logic pend;
    logic run;
    logic [31:0] m;
    logic [31:0] mv;
    logic [1:0]  seen;
    pend = cs.req != cs.ack_s2;
    m = merge_bytes(32'h0, cs.wdata, cs.wstrb);
    mv = 32'h0;
    seen = cs.rt_s2 ^ cs.rt_s3;
    // gated clock runs only while work is pending or
    // a frame is going out; free clock runs whenever en is set
    run = en && (!cs.ctrl[ssp_pkg::C_GATED] || pend || cs.busy_s2);
    next_cs = cs;
    // two-stage syncs; first stage feeds only the second
    next_cs.pin_s1 = pin_in_v;
    next_cs.pin_s2 = cs.pin_s1;
    next_cs.ack_s1 = ls.ack;
    next_cs.ack_s2 = cs.ack_s1;
    next_cs.busy_s1 = ls.active;
    next_cs.busy_s2 = cs.busy_s1;
    next_cs.rt_s1 = {async_tgl, sync_tgl};
    next_cs.rt_s2 = cs.rt_s1;
    next_cs.rt_s3 = cs.rt_s2;
    // address and data may arrive in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_cs.aw_have = 1'b1;
      next_cs.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_cs.w_have = 1'b1;
      next_cs.wdata = s_axi_wdata_in;
      next_cs.wstrb = s_axi_wstrb_in;
    end
    if (cs.bvalid && s_axi_bready_in) begin
      next_cs.bvalid = 1'b0;
    end
    // both halves held: do the write, answer next cycle
    if (cs.aw_have && cs.w_have) begin
      next_cs.aw_have = 1'b0;
      next_cs.w_have = 1'b0;
      next_cs.bvalid = 1'b1;
      next_cs.bresp = reg_mapped(cs.aw_addr) ? ssp_pkg::RESP_OKAY
                                             : ssp_pkg::RESP_SLVERR;
      case (cs.aw_addr)
        ssp_pkg::OFS_CTRL: begin
          // mode select and pin directions
          mv = merge_bytes({23'h0, cs.ctrl}, cs.wdata, cs.wstrb);
          next_cs.ctrl = mv[8:0];
        end
        ssp_pkg::OFS_DIV: begin
          next_cs.div = cs.wstrb[0] ? cs.wdata[7:0] : cs.div;
        end
        ssp_pkg::OFS_TX: begin
          // ignored while the last word is not yet taken,
          // so the link side never sees a word change
          if (!pend) begin
            mv = merge_bytes({8'h0, cs.tx}, cs.wdata, cs.wstrb);
            next_cs.tx = mv[23:0];
            next_cs.req = ~cs.req;
          end
        end
        ssp_pkg::OFS_FLAG: begin
          next_cs.flag = cs.wstrb[0] ? cs.wdata[1:0] : cs.flag;
        end
        ssp_pkg::OFS_GDIR: begin
          next_cs.gdir = m[5:0] | (cs.gdir & ~{6{cs.wstrb[0]}});
        end
        ssp_pkg::OFS_GOUT: begin
          next_cs.gout = m[5:0] | (cs.gout & ~{6{cs.wstrb[0]}});
        end
        default: begin
          // read-only or unmapped: nothing stored
        end
      endcase
    end
    if (cs.rvalid && s_axi_rready_in) begin
      next_cs.rvalid = 1'b0;
    end
    // read answer registered one cycle after the address
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_cs.rvalid = 1'b1;
      next_cs.rresp = reg_mapped(s_axi_araddr_in) ? ssp_pkg::RESP_OKAY
                                                  : ssp_pkg::RESP_SLVERR;
      case (s_axi_araddr_in)
        ssp_pkg::OFS_CTRL: next_cs.rdata = {23'h0, cs.ctrl};
        ssp_pkg::OFS_DIV:  next_cs.rdata = {24'h0, cs.div};
        ssp_pkg::OFS_TX:   next_cs.rdata = {8'h0, cs.tx};
        ssp_pkg::OFS_RX: begin
          // reading the word empties the receive side
          next_cs.rdata = {24'h0, cs.rx_data};
          next_cs.rx_full = 1'b0;
          next_cs.ovr = 1'b0;
        end
        ssp_pkg::OFS_STAT: begin
          next_cs.rdata = {26'h0, cs.busy_s2, cs.pin_s2[ssp_pkg::P_C1],
                           cs.pin_s2[ssp_pkg::P_C0], cs.ovr, cs.rx_full, pend};
        end
        ssp_pkg::OFS_FLAG: begin
          // sampled flag pins beside the written levels
          next_cs.rdata = {28'h0, cs.pin_s2[ssp_pkg::P_C1],
                           cs.pin_s2[ssp_pkg::P_C0], cs.flag};
        end
        ssp_pkg::OFS_GDIR: next_cs.rdata = {26'h0, cs.gdir};
        ssp_pkg::OFS_GOUT: next_cs.rdata = {26'h0, cs.gout};
        ssp_pkg::OFS_GIN:  next_cs.rdata = {26'h0, cs.pin_s2};
        default:           next_cs.rdata = 32'h0;
      endcase
    end
    // new word from the lane that the mode selects;
    // after the read clear so an arriving word wins
    if (en && (sync_mode ? seen[0] : seen[1])) begin
      next_cs.rx_data = sync_mode ? sync_word : async_word;
      next_cs.ovr = next_cs.rx_full;
      next_cs.rx_full = 1'b1;
    end
    // bit clock divider, held low while stopped
    if (!run) begin
      next_cs.dcnt = 8'h00;
      next_cs.sclk = 1'b0;
    end else if (cs.dcnt == cs.div) begin
      next_cs.dcnt = 8'h00;
      next_cs.sclk = ~cs.sclk;
    end else begin
      next_cs.dcnt = cs.dcnt + 8'h01;
    end
  end

  // system-clock state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs <= '0;
      cs.ctrl <= ssp_pkg::CTRL_RESET;
      cs.div <= ssp_pkg::DIV_RESET;
      cs.gdir <= ssp_pkg::GPIO_RESET;
      cs.gout <= ssp_pkg::GPIO_RESET;
    end else begin
      cs <= next_cs;
    end
  end

  // link-clock next state: transmit framing
  always_comb begin
    logic lpend;
    logic can_go;
    logic go;
    logic last;
    go = 1'b0;
    lpend = ls.req_s2 != ls.ack;
    last = ls.active && (ls.cnt == ssp_pkg::BIT_LAST);
    can_go = !ls.active || last;
    next_ls = ls;
    next_ls.cfg_s1 = {cs.ctrl[ssp_pkg::C_C1TX], cs.ctrl[ssp_pkg::C_C0TX],
                      cs.ctrl[ssp_pkg::C_FSDIR], sync_mode, en};
    next_ls.cfg_s2 = ls.cfg_s1;
    next_ls.req_s1 = cs.req;
    next_ls.req_s2 = ls.req_s1;
    next_ls.fs = 1'b0;
    // output sync: start when a word waits;
    // input sync: start on the partner's pulse
    if (ls.cfg_s2[2]) begin
      go = ls.cfg_s2[0] && can_go && lpend;
    end else begin
      go = ls.cfg_s2[0] && can_go && serial_frame_sync_pin_in;
    end
    if (go) begin
      // first bit and frame sync leave together
      next_ls.fs = ls.cfg_s2[2];
      next_ls.sh = lpend ? cs.tx : 24'h0;
      next_ls.ack = ls.req_s2;
      next_ls.active = 1'b1;
      next_ls.cnt = 4'h0;
    end else if (last || !ls.cfg_s2[0]) begin
      // clearing the shifters idles the pins low
      next_ls.active = 1'b0;
      next_ls.sh = 24'h0;
    end else if (ls.active) begin
      for (int i = 0; i < 3; i++) begin
        next_ls.sh[i] = {ls.sh[i][6:0], 1'b0};
      end
      next_ls.cnt = ls.cnt + 4'h1;
    end
  end

  // link-clock state register
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end

  // receiver on the bit clock: sync mode
  serial_rx_lane u_sync_lane (
    .clk_in     (link_clk_in),
    .nrst_in    (nrst_in),
    .data_in    (serial_rx_data_pin_in),
    .fs_in      (serial_frame_sync_pin_in),
    .int_fs_in  (ls.fs),
    .cfg_in     ({cs.ctrl[ssp_pkg::C_FSDIR], 1'b0, en && sync_mode}),
    .word_out   (sync_word),
    .tgl_out    (sync_tgl),
    .fs_gen_out ()
  );

  // receiver on control pin zero: async mode
  serial_rx_lane u_async_lane (
    .clk_in     (rx_clk_in),
    .nrst_in    (nrst_in),
    .data_in    (serial_rx_data_pin_in),
    .fs_in      (serial_ctrl_pin_one_in),
    .int_fs_in  (1'b0),
    .cfg_in     ({1'b0, cs.ctrl[ssp_pkg::C_C1DIR], en && !sync_mode}),
    .word_out   (async_word),
    .tgl_out    (async_tgl),
    .fs_gen_out (async_fs)
  );

  // pin roles; all pins fall back to general i/o while en is clear
  always_comb begin
    pin_out_v = cs.gout;
    pin_oe_v = cs.gdir;
    if (en) begin
      pin_out_v[ssp_pkg::P_TXD] = ls.sh[0][7];
      pin_oe_v[ssp_pkg::P_TXD] = 1'b1;
      pin_out_v[ssp_pkg::P_RXD] = 1'b0;
      pin_oe_v[ssp_pkg::P_RXD] = 1'b0;
      pin_out_v[ssp_pkg::P_SCK] = cs.sclk;
      pin_oe_v[ssp_pkg::P_SCK] = cs.ctrl[ssp_pkg::C_SCKDIR];
      if (sync_mode) begin
        // pin zero: second transmitter or flag
        if (cs.ctrl[ssp_pkg::C_C0TX]) begin
          pin_out_v[ssp_pkg::P_C0] = ls.sh[1][7];
          pin_oe_v[ssp_pkg::P_C0] = 1'b1;
        end else begin
          pin_out_v[ssp_pkg::P_C0] = cs.flag[0];
          pin_oe_v[ssp_pkg::P_C0] = cs.ctrl[ssp_pkg::C_C0DIR];
        end
        // pin one: third transmitter or flag
        if (cs.ctrl[ssp_pkg::C_C1TX]) begin
          pin_out_v[ssp_pkg::P_C1] = ls.sh[2][7];
          pin_oe_v[ssp_pkg::P_C1] = 1'b1;
        end else begin
          pin_out_v[ssp_pkg::P_C1] = cs.flag[1];
          pin_oe_v[ssp_pkg::P_C1] = cs.ctrl[ssp_pkg::C_C1DIR];
        end
      end else begin
        // async: receive clock and receive sync
        pin_out_v[ssp_pkg::P_C0] = cs.sclk;
        pin_oe_v[ssp_pkg::P_C0] = cs.ctrl[ssp_pkg::C_C0DIR];
        pin_out_v[ssp_pkg::P_C1] = async_fs;
        pin_oe_v[ssp_pkg::P_C1] = cs.ctrl[ssp_pkg::C_C1DIR];
      end
      pin_out_v[ssp_pkg::P_FS] = ls.fs;
      pin_oe_v[ssp_pkg::P_FS] = cs.ctrl[ssp_pkg::C_FSDIR];
    end
  end

  // pin vectors out to single ports
  assign serial_tx_data_pin_out = pin_out_v[ssp_pkg::P_TXD];
  assign serial_tx_data_pin_oe_out = pin_oe_v[ssp_pkg::P_TXD];
  assign serial_rx_data_pin_out = pin_out_v[ssp_pkg::P_RXD];
  assign serial_rx_data_pin_oe_out = pin_oe_v[ssp_pkg::P_RXD];
  assign serial_bit_clock_pin_out = pin_out_v[ssp_pkg::P_SCK];
  assign serial_bit_clock_pin_oe_out = pin_oe_v[ssp_pkg::P_SCK];
  assign serial_ctrl_pin_zero_out = pin_out_v[ssp_pkg::P_C0];
  assign serial_ctrl_pin_zero_oe_out = pin_oe_v[ssp_pkg::P_C0];
  assign serial_ctrl_pin_one_out = pin_out_v[ssp_pkg::P_C1];
  assign serial_ctrl_pin_one_oe_out = pin_oe_v[ssp_pkg::P_C1];
  assign serial_frame_sync_pin_out = pin_out_v[ssp_pkg::P_FS];
  assign serial_frame_sync_pin_oe_out = pin_oe_v[ssp_pkg::P_FS];
endmodule

// file: verification/ssp_chk.sv
`timescale 1ns/1ps
// watches bus answers and frame sync spacing
module ssp_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic link_clk_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic serial_frame_sync_pin_out,
  input wire logic serial_frame_sync_pin_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out) else $error("rvalid dropped");
  w_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("no bvalid");
  r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("no rvalid");
  ar_refused_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("arready while rvalid");
  aw_refused_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
    else $error("awready while bvalid");
  w_refused_a: assert property (s_axi_bvalid_out |-> !s_axi_wready_out)
    else $error("wready while bvalid");
  // a made frame sync lasts one bit, next one no sooner than a word later
  fs_gap_a: assert property (@(posedge link_clk_in) disable iff (!nrst_in)
    serial_frame_sync_pin_oe_out && serial_frame_sync_pin_out
    |=> (!serial_frame_sync_pin_out)[*7]) else $error("frame sync too long");
  w_done_c: cover property (s_axi_bvalid_out && s_axi_bready_in);
  r_done_c: cover property (s_axi_rvalid_out && s_axi_rready_in);
  fs_seen_c: cover property (@(posedge link_clk_in) serial_frame_sync_pin_out);
endmodule
bind enhanced_sync_serial_unit ssp_chk chk (.clk_in, .nrst_in, .link_clk_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .serial_frame_sync_pin_out,
  .serial_frame_sync_pin_oe_out);

// file: verification/ssp_codec.sv
`timescale 1ns/1ps
// codec stand-in: plays transmitted bits back on the receive line
module ssp_codec (
  input  wire logic bclk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  initial rxd_out = 1'b0;
  // falling edge, clear of the device's rising sample
  always @(negedge bclk_in) rxd_out <= txd_in;
endmodule

// file: verification/enhanced_sync_serial_unit_bench.sv
`timescale 1ns/1ps
module enhanced_sync_serial_unit_bench;
  logic        clk_in = 1'b0, nrst_in = 1'b0, bclk = 1'b0, ext_on = 1'b0, mode = 1'b0;
  logic        awv, awr, wvl, wrr, bv, brd, arv, arr, rv, rrd, cod;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata, q;
  logic [1:0]  bresp, rresp, s;
  logic [5:0]  po, pe, pin, drv, ext;
  logic [3:0]  ws = 4'hf;
  logic [15:0] r = 16'hd4e4;
  int          failures = 0, n_tests = 0, cyc = 0;
  // outside level: codec and link clock in serial mode, bench bits otherwise
  assign ext = {drv[5:3], mode ? bclk & ext_on : drv[2], mode ? cod : drv[1], drv[0]};
  assign pin = (pe & po) | (~pe & ext);
  enhanced_sync_serial_unit dut (.clk_in(clk_in), .nrst_in(nrst_in), .link_clk_in(pin[2]),
    .rx_clk_in(pin[3]), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wvl), .s_axi_wready_out(wrr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brd), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrd), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .serial_tx_data_pin_in(pin[0]), .serial_tx_data_pin_out(po[0]),
    .serial_tx_data_pin_oe_out(pe[0]), .serial_rx_data_pin_in(pin[1]),
    .serial_rx_data_pin_out(po[1]), .serial_rx_data_pin_oe_out(pe[1]),
    .serial_bit_clock_pin_in(pin[2]), .serial_bit_clock_pin_out(po[2]),
    .serial_bit_clock_pin_oe_out(pe[2]), .serial_ctrl_pin_zero_in(pin[3]),
    .serial_ctrl_pin_zero_out(po[3]), .serial_ctrl_pin_zero_oe_out(pe[3]),
    .serial_ctrl_pin_one_in(pin[4]), .serial_ctrl_pin_one_out(po[4]),
    .serial_ctrl_pin_one_oe_out(pe[4]), .serial_frame_sync_pin_in(pin[5]),
    .serial_frame_sync_pin_out(po[5]), .serial_frame_sync_pin_oe_out(pe[5]));
  ssp_codec codec (.bclk_in(pin[2]), .txd_in(pin[0]), .rxd_out(cod));
  always #2.5 clk_in = ~clk_in;
  // link clock, phase offset from the system clock
  initial #1.3 forever #80 bclk = ~bclk;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      failures++;
    end
  endtask
  // one bus cycle; answer lands in q and s
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, dn, ta, tw, tr;
    pa = 1'b1;
    pw = w;
    dn = 1'b0;
    @(posedge clk_in);
    {awv, wvl, brd, awa, wd} <= {w, w, w, a, d};
    {arv, rrd, ara} <= {!w, !w, a};
    while (!dn) begin
      // readies settle mid-cycle, equal to what the next edge samples
      @(negedge clk_in);
      ta = pa & (w ? awr : arr);
      tw = pw & wrr;
      tr = !pa & !pw & (w ? bv : rv);
      {q, s} = {rdata, w ? bresp : rresp};
      @(posedge clk_in);
      if (ta) {awv, arv} <= 2'h0;
      if (ta) pa = 1'b0;
      if (tw) wvl <= 1'b0;
      if (tw) pw = 1'b0;
      if (tr) {brd, rrd} <= 2'h0;
      if (tr) dn = 1'b1;
    end
  endtask
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {awv, wvl, brd, arv, rrd} = 5'h0;
    {awa, ara, wd, drv} = '0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    bus(0, ssp_pkg::OFS_CTRL, 0);
    chk(q, 32'h0);
    bus(0, ssp_pkg::OFS_DIV, 0);
    chk(q, 32'h0f);
    chk({26'h0, pe}, 32'h0);
    bus(0, 8'h3c, 0);
    chk({q[29:0], s}, {30'h0, ssp_pkg::RESP_SLVERR});
    r = lf(r);
    drv <= r[5:0];
    bus(1, ssp_pkg::OFS_GDIR, {26'h0, r[11:6]});
    bus(1, ssp_pkg::OFS_GOUT, {26'h0, r[15:10]});
    // byte lane one only: directions must stay
    ws <= 4'h2;
    bus(1, ssp_pkg::OFS_GDIR, 0);
    ws <= 4'hf;
    repeat (4) @(posedge clk_in);
    bus(0, ssp_pkg::OFS_GIN, 0);
    chk(q, {26'h0, (r[11:6] & r[15:10]) | (~r[11:6] & r[5:0])});
    chk({26'h0, pe}, {26'h0, r[11:6]});
    $display("general pin test done");
    bus(1, ssp_pkg::OFS_CTRL, 32'h1b);
    bus(1, ssp_pkg::OFS_FLAG, {30'h0, r[1:0]});
    chk({30'h0, po[4:3]}, {30'h0, r[1:0]});
    repeat (4) @(posedge clk_in);
    bus(0, ssp_pkg::OFS_FLAG, 0);
    chk(q, {28'h0, r[1:0], r[1:0]});
    $display("flag test done");
    mode <= 1'b1;
    // device free clock, outside free clock, device gated clock
    for (int k = 0; k < 3; k++) begin
      ext_on <= k[0];
      bus(1, ssp_pkg::OFS_CTRL, k[0] ? 32'h23 : {23'h0, k[1], 8'h27});
      r = lf(r);
      bus(1, ssp_pkg::OFS_TX, {24'h0, r[7:0]});
      q = '0;
      while (q[1] !== 1'b1) bus(0, ssp_pkg::OFS_STAT, 0);
      bus(0, ssp_pkg::OFS_RX, 0);
      chk(q, {24'h0, r[7:0]});
      $display("serial test %0d done", k);
    end
    // async: device clocks and frames its own receiver, idle line
    bus(1, ssp_pkg::OFS_CTRL, 32'h19);
    q = '0;
    while (q[1] !== 1'b1) bus(0, ssp_pkg::OFS_STAT, 0);
    chk({30'h0, pe[4:3]}, 32'h3);
    bus(0, ssp_pkg::OFS_RX, 0);
    chk(q, 32'h0);
    $display("async test done");
    conclude();
  end
endmodule
